// ==== mem_map_map.vh ====
// Constants for the program and data address organisation block.
// Assumes inclusion by bare name from the design files.
// Overview of operation
// RQ1 - A 13-bit program counter addresses up to 8K words of 14 bits.
// RQ2 - Large variants hold 8K program words, small variants only 4K.
// RQ3 - Fetches above the implemented store wrap by dropping upper bits.
// RQ4 - Any reset loads the program counter with zero, fetching from 0000h.
// RQ5 - A taken interrupt redirects fetch to program address 0004h.
// RQ6 - Program and data stores have separate buses usable in one cycle.
// RQ7 - Status bits 6:5 pick data bank 0 to 3 from codes 00 to 11.
// RQ8 - Each bank spans offsets 00h to 7Fh, 128 byte locations.
// RQ9 - Special registers sit at low offsets, general RAM above them.
// RQ10 - Each bank holds special registers; some mirror one physical one.
// RQ11 - Registers are reached directly or through an indirect pointer.
// RQ12 - Direct addresses put the bank bits above the 7-bit offset.
`ifndef MEM_MAP_MAP_VH
`define MEM_MAP_MAP_VH
`define PC_W 13
`define INSN_W 14
`define PC_RESET 13'h0000
`define PC_INT_VEC 13'h0004
`define BANK_HI_BIT 6
`define BANK_LO_BIT 5
`define OFS_W 7
`define DADDR_W 9
`define SFR_TOP 7'h1F
`define MIRROR_LO 7'h70
`define IND_OFS 7'h00
`define STATUS_OFS 7'h03
`define PTR_OFS 7'h04
`endif

// ==== prog_store.v ====
// Program word store with a registered read port.
// Assumes one synchronous write port for loading code.
`timescale 1ns/1ns
`default_nettype none
module prog_store #(
  parameter AW = 12,
  parameter DW = 14
) (
  input wire clk_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [DW-1:0] rd_data_o,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// ==== mem_map_bank.v ====
// Program counter, program store and data bank address former.
// Assumes the core supplies next-fetch and interrupt requests synchronously.
`include "mem_map_map.vh"
`timescale 1ns/1ns
`default_nettype none
module mem_map_bank #(
  parameter IMPL_AW = 13
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Fetch control
  input wire fetch_i,
  input wire load_pc_i,
  input wire [`PC_W-1:0] load_addr_i,
  input wire int_take_i,
  // Program store loading
  input wire prog_wr_i,
  input wire [`PC_W-1:0] prog_wr_addr_i,
  input wire [`INSN_W-1:0] prog_wr_data_i,
  // Fetch result
  output reg [`PC_W-1:0] pc_o,
  output wire [`INSN_W-1:0] insn_o,
  // Data access request
  input wire data_req_i,
  input wire indirect_i,
  input wire [`OFS_W-1:0] ofs_i,
  input wire [7:0] status_i,
  input wire [7:0] indirect_pointer_i,
  input wire indirect_bank_i,
  // Data address result
  output reg [`DADDR_W-1:0] daddr_o,
  output reg daddr_valid_o,
  output reg is_sfr_o,
  output reg is_ram_o,
  output reg is_mirror_o,
  output reg [1:0] bank_o
);
  reg [`PC_W-1:0] pc_nxt;
  wire [IMPL_AW-1:0] fetch_addr;
  wire bank_select_high;
  wire bank_select_low;
  wire [1:0] bank_sel;
  wire [`OFS_W-1:0] ofs_eff;
  wire [`DADDR_W-1:0] daddr_nxt;

  // Low bits only; upper bits ignored so accesses wrap
  assign fetch_addr = pc_nxt[IMPL_AW-1:0]; // RQ3 RQ2

  // Separate instruction store, independent of data path
  prog_store #(.AW(IMPL_AW), .DW(`INSN_W)) u_store ( // RQ6
    .clk_i(clk_i),
    .rd_addr_i(fetch_addr),
    .rd_data_o(insn_o),
    .wr_en_i(prog_wr_i),
    .wr_addr_i(prog_wr_addr_i[IMPL_AW-1:0]),
    .wr_data_i(prog_wr_data_i)
  );

  always @* begin
    pc_nxt = pc_o;
    if (int_take_i) begin
      pc_nxt = `PC_INT_VEC; // RQ5
    end else if (load_pc_i) begin
      pc_nxt = load_addr_i;
    end else if (fetch_i) begin
      pc_nxt = pc_o + 13'h0001; // RQ1
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o <= `PC_RESET; // RQ4
    end else begin
      pc_o <= pc_nxt;
    end
  end

  // Bank choice from status bits 6:5
  assign bank_select_high = status_i[`BANK_HI_BIT];
  assign bank_select_low = status_i[`BANK_LO_BIT];
  assign bank_sel = {bank_select_high, bank_select_low}; // RQ7

  // Pointer byte gives offset, its top bit the low bank bit
  assign ofs_eff = (indirect_i && ofs_i == `IND_OFS) ?
    indirect_pointer_i[`OFS_W-1:0] : ofs_i; // RQ11
  assign daddr_nxt = (indirect_i && ofs_i == `IND_OFS) ?
    {indirect_bank_i, indirect_pointer_i} : {bank_sel, ofs_i}; // RQ12 RQ8

  function is_shared_sfr;
    input [`OFS_W-1:0] o;
    begin
      is_shared_sfr = (o == `IND_OFS) || (o == `STATUS_OFS) ||
        (o == `PTR_OFS) || (o >= `MIRROR_LO);
    end
  endfunction

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      daddr_o <= 9'h000;
      daddr_valid_o <= 1'b0;
      is_sfr_o <= 1'b0;
      is_ram_o <= 1'b0;
      is_mirror_o <= 1'b0;
      bank_o <= 2'h0;
    end else begin
      daddr_valid_o <= data_req_i;
      if (data_req_i) begin
        daddr_o <= daddr_nxt;
        bank_o <= daddr_nxt[8:7];
        is_sfr_o <= (ofs_eff <= `SFR_TOP); // RQ9 RQ10
        is_ram_o <= (ofs_eff > `SFR_TOP); // RQ9
        is_mirror_o <= is_shared_sfr(ofs_eff); // RQ10
      end
    end
  end
endmodule
`default_nettype wire

// ==== core_stub.sv ====
// Core fetch model: requests a fetch one cycle after run_i.
`timescale 1ns/1ns
`default_nettype none
module core_stub (
  input wire logic clk_i,
  input wire logic run_i,
  output var logic fetch_o
);
  initial fetch_o = 1'h0;
  always @(posedge clk_i) fetch_o <= #1 run_i;
endmodule
`default_nettype wire

// ==== mm_properties.sv ====
// Port checker for mem_map_bank, bound below.
`timescale 1ns/1ns
`default_nettype none
module mm_properties (
  input wire logic clk_i, rst_n_i, fetch_i, load_pc_i, int_take_i,
  input wire logic data_req_i, indirect_i, is_sfr_o, is_mirror_o,
  input wire logic daddr_valid_o, input wire logic [12:0] pc_o,
  input wire logic [6:0] ofs_i, input wire logic [8:0] daddr_o,
  input wire logic [7:0] status_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic adv = fetch_i && !load_pc_i && !int_take_i;
  wire logic dir = data_req_i && !indirect_i;
  a_pc_step: assert property (
    adv |=> pc_o == $past(pc_o) + 13'h1) else $error("pc step");
  a_pc_hold: assert property (
    !fetch_i && !load_pc_i && !int_take_i |=> $stable(pc_o)) else $error("hold");
  a_int_vector: assert property (
    int_take_i |=> pc_o == 13'h0004) else $error("vector");
  a_bank_sel: assert property (
    dir |=> daddr_o[8:7] == $past(status_i[6:5])) else $error("bank");
  a_in_bank: assert property (
    dir |=> daddr_o[6:0] == $past(ofs_i)) else $error("offset");
  a_sfr_low: assert property (
    dir |=> is_sfr_o == ($past(ofs_i) <= 7'h1F)) else $error("sfr");
  a_mirror_top: assert property (
    dir && ofs_i >= 7'h70 |=> is_mirror_o) else $error("mirror");
  a_valid_next: assert property (
    data_req_i |=> daddr_valid_o) else $error("valid");
endmodule
bind mem_map_bank mm_properties mm_properties_inst (.*);
`default_nettype wire

// ==== mem_map_bank_tb.sv ====
// Bench: 4K variant of mem_map_bank fed by core_stub.
`timescale 1ns/1ns
`default_nettype none
module mem_map_bank_tb;
  logic clk_i = 0, rst_n_i = 0, run_i = 0, load_pc_i = 0, int_take_i = 0;
  logic prog_wr_i = 0, data_req_i = 0, indirect_i = 0, indirect_bank_i = 0;
  logic fetch_i, daddr_valid_o, is_sfr_o, is_ram_o, is_mirror_o;
  logic [12:0] load_addr_i = 0, prog_wr_addr_i = 0, pc_o;
  logic [13:0] prog_wr_data_i = 0, insn_o;
  logic [6:0] ofs_i = 0;
  logic [7:0] status_i = 0, indirect_pointer_i = 0;
  logic [8:0] daddr_o, ea;
  logic [13:0] q[$];
  logic [1:0] bank_o;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  initial forever #5 clk_i = ~clk_i;
  core_stub core_stub_inst (.clk_i, .run_i, .fetch_o(fetch_i));
  mem_map_bank #(.IMPL_AW(12)) mem_map_bank_inst (.*);
  task chk(input logic [13:0] g, e);
    n_tests++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("wrong value at %0t: %h", $time, g);
  endtask
  // Expected {mirror, ram, sfr} for an in-bank offset
  function automatic logic [2:0] exp_flags(input logic [6:0] o);
    return {o == 7'h00 || o == 7'h03 || o == 7'h04 || o >= 7'h70,
      o > 7'h1F, o <= 7'h1F};
  endfunction
  task final_report;
    $display("%0d checks %0d errors", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Outputs settled by the falling edge
  always @(negedge clk_i) begin
    cyc++;
    if (cyc == 400) error_cnt++;
    if (cyc == 400) final_report;
    if (daddr_valid_o === 1'h1)
      chk({is_mirror_o, is_ram_o, is_sfr_o, bank_o, daddr_o},
        q.pop_front());
  end
  initial begin
    void'($urandom(32'hC75E));
    step(4);
    rst_n_i = 1;
    chk(pc_o, 0);
    prog_wr_i = 1; prog_wr_addr_i = 13'h1005; prog_wr_data_i = 14'($urandom);
    step(1);
    prog_wr_i = 0; load_pc_i = 1; load_addr_i = 13'h1004;
    step(1);
    load_pc_i = 0; run_i = 1;
    step(1);
    run_i = 0;
    step(2);
    chk(pc_o, 13'h1005);
    chk(insn_o, prog_wr_data_i);
    int_take_i = 1; load_pc_i = 1;
    step(1);
    int_take_i = 0; load_pc_i = 0; run_i = 1; data_req_i = 1;
    chk(pc_o, 13'h0004);
    $display("fetch test done");
    for (int b = 0; b < 5; b++) begin
      indirect_i = b == 4;
      indirect_pointer_i = 8'($urandom);
      indirect_bank_i = 1'($urandom);
      status_i = {1'($urandom), 2'(b), 5'($urandom)};
      ofs_i = b == 4 ? 7'h00 :
        b == 2 ? 7'($urandom) | 7'h01 : 7'(b * 32 + 31);
      ea = b == 4 ? {indirect_bank_i, indirect_pointer_i} : {2'(b), ofs_i};
      q.push_back({exp_flags(ea[6:0]), ea[8:7], ea});
      step(1);
    end
    run_i = 0; data_req_i = 0; indirect_i = 0;
    step(3);
    chk(pc_o, 13'h0009);
    chk(14'(q.size()), 0);
    $display("data test done");
    rst_n_i = 0;
    step(1);
    chk(pc_o, 0);
    $display("reset test done");
    final_report;
  end
endmodule
`default_nettype wire
